// ===== hdl/mls_pkg.sv
package mls_pkg;
  // ----------------------------------------
  // array dimensions
  // ----------------------------------------
  localparam int MLS_NUM_IN = 12;
  localparam int MLS_NUM_ST = 10;
  localparam int MLS_NUM_OUT = 4;
  localparam int MLS_NUM_TERM = 48;
  localparam int MLS_NUM_VAR = MLS_NUM_IN + MLS_NUM_ST;
  localparam int MLS_NUM_PIN = 8;
  localparam int MLS_NUM_SHARED = 4;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] MLS_OFF_CTRL = 12'h000;
  localparam logic [11:0] MLS_OFF_STATUS = 12'h004;
  localparam logic [11:0] MLS_OFF_TSEL = 12'h008;
  localparam logic [11:0] MLS_OFF_TTRUE = 12'h00c;
  localparam logic [11:0] MLS_OFF_TCOMP = 12'h010;
  localparam logic [11:0] MLS_OFF_TSET = 12'h014;
  localparam logic [11:0] MLS_OFF_TRST = 12'h018;
  localparam logic [11:0] MLS_OFF_TCTL = 12'h01c;

  // ----------------------------------------
  // control field positions and reset values
  // ----------------------------------------
  localparam int MLS_CTRL_OEMODE = 0;
  localparam int MLS_CTRL_LOCK = 1;
  localparam int MLS_TCTL_CIN = 0;
  localparam int MLS_TCTL_CDRV = 1;
  localparam logic [31:0] MLS_CTRL_RST = 32'h0000_0000;
  localparam logic [13:0] MLS_FF_RST = 14'h3fff;

  // ----------------------------------------
  // AHB encodings
  // ----------------------------------------
  localparam logic [1:0] MLS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] MLS_HTRANS_SEQ = 2'h3;
endpackage

// ===== hdl/mls_term_array.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// AND array, complement array and OR array
// ----------------------------------------
module mls_term_array
  import mls_pkg::*;
(
  // programming
  input wire logic [MLS_NUM_TERM-1:0][MLS_NUM_VAR-1:0] useTrue,
  input wire logic [MLS_NUM_TERM-1:0][MLS_NUM_VAR-1:0] useComp,
  input wire logic [MLS_NUM_TERM-1:0][13:0] connSet,
  input wire logic [MLS_NUM_TERM-1:0][13:0] connRst,
  input wire logic [MLS_NUM_TERM-1:0] cplIn,
  input wire logic [MLS_NUM_TERM-1:0] cplDrv,
  // variables
  input wire logic [MLS_NUM_VAR-1:0] vars,
  // commands
  output logic [13:0] setCmd,
  output logic [13:0] rstCmd
);
  import mls_pkg::*;

  logic [MLS_NUM_TERM-1:0] termRaw;
  logic [MLS_NUM_TERM-1:0] termAct;
  logic cplVar;

  // a term with both literals intact on any variable is dead
  function automatic logic matchTerm(input logic [MLS_NUM_VAR-1:0] t,
                                     input logic [MLS_NUM_VAR-1:0] c,
                                     input logic [MLS_NUM_VAR-1:0] v);
    matchTerm = &((~t | v) & (~c | ~v));
  endfunction

  always_comb
  begin
    for (int i = 0; i < MLS_NUM_TERM; i++)
    begin
      termRaw[i] = matchTerm(useTrue[i], useComp[i], vars);
    end
  end

  // complement variable: low when any driving term fires; one pass, no loop
  assign cplVar = ~|(termRaw & cplDrv);
  assign termAct = termRaw & (~cplIn | {MLS_NUM_TERM{cplVar}});

  always_comb
  begin
    setCmd = '0;
    rstCmd = '0;
    for (int i = 0; i < MLS_NUM_TERM; i++)
    begin
      if (termAct[i])
      begin
        setCmd = setCmd | connSet[i];
        rstCmd = rstCmd | connRst[i];
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/mls_sequencer.sv
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - mealy machine: ten state and four output set/reset flip-flops, optional preset
// - after power-on reset every state and output flip-flop reads one
// - product terms see twelve inputs and ten fed-back state bits, 48 terms
// - four lowest state bits also drive output pins, widening outputs to eight
// - each term takes every variable true, inverted or don't care
// - or array forms set/reset commands, applied only at rising clock edge
// - optional complement variable usable inside product terms
// - preset pin configured once as preset or output enable, never both; here CTRL stays writable until the lock bit is set
// - hold on neither, clear on reset, set on set; both is illegal
// - preset high forces ones and inhibits clocking until a full clock pulse; here clocking stays held for three more edges after the filtered level drops
// - output enable high floats all outputs, low drives; registers untouched
module mls_sequencer
  import mls_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // machine pins
  input wire logic [MLS_NUM_IN-1:0] logicInputs,
  input wire logic presetOrOutputEnable,
  output logic [MLS_NUM_PIN-1:0] pinOut,
  output logic [MLS_NUM_PIN-1:0] pinOe_n,
  output logic [MLS_NUM_ST-1:0] stateBits
);
  import mls_pkg::*;

  // ----------------------------------------
  // programming store
  // ----------------------------------------
  logic [MLS_NUM_TERM-1:0][MLS_NUM_VAR-1:0] useTrue_r;
  logic [MLS_NUM_TERM-1:0][MLS_NUM_VAR-1:0] useComp_r;
  logic [MLS_NUM_TERM-1:0][13:0] connSet_r;
  logic [MLS_NUM_TERM-1:0][13:0] connRst_r;
  logic [MLS_NUM_TERM-1:0] cplIn_r;
  logic [MLS_NUM_TERM-1:0] cplDrv_r;
  logic [5:0] termSel_r;
  logic oeMode_r;
  logic lock_r;

  // ----------------------------------------
  // bus and pin state
  // ----------------------------------------
  logic wrPend_r;
  logic [11:0] wrAddr_r;
  logic [2:0] pinSync_r;
  logic presetLvl_r;
  logic [2:0] presetSeq_r;
  logic [MLS_NUM_IN-1:0] inSyncA_r;
  logic [MLS_NUM_IN-1:0] inSyncB_r;
  logic [MLS_NUM_IN-1:0] inSyncC_r;
  logic [MLS_NUM_IN-1:0] inLvl_r;
  logic [MLS_NUM_ST-1:0] state_r;
  logic [MLS_NUM_OUT-1:0] outReg_r;
  logic [MLS_NUM_PIN-1:0] pinOut_r;
  logic [MLS_NUM_PIN-1:0] pinOe_n_r;
  logic [13:0] setCmd;
  logic [13:0] rstCmd;
  logic [13:0] ffNow;
  logic [13:0] ffNxt;
  logic presetAct;
  logic clkRun;
  logic outOff;
  logic illegalSr;
  logic addrTake;
  logic [5:0] rdSel;

  // ----------------------------------------
  // logic array
  // ----------------------------------------
  mls_term_array uArray (
    .useTrue(useTrue_r),
    .useComp(useComp_r),
    .connSet(connSet_r),
    .connRst(connRst_r),
    .cplIn(cplIn_r),
    .cplDrv(cplDrv_r),
    .vars({state_r, inLvl_r}),
    .setCmd(setCmd),
    .rstCmd(rstCmd)
  );

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinSync_r <= 3'h0;
      inSyncA_r <= '0;
      inSyncB_r <= '0;
      inSyncC_r <= '0;
      inLvl_r <= '0;
    end
    else
    begin
      pinSync_r <= {pinSync_r[1:0], presetOrOutputEnable};
      inSyncA_r <= logicInputs;
      inSyncB_r <= inSyncA_r;
      inSyncC_r <= inSyncB_r;
      // per bit: a change counts once stages two and three agree
      inLvl_r <= (inSyncB_r & inSyncC_r) | (inLvl_r & (inSyncB_r ^ inSyncC_r));
    end
  end

  // filtered level: changes only once stages two and three agree
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      presetLvl_r <= 1'b0;
    end
    else if (pinSync_r[2] == pinSync_r[1])
    begin
      presetLvl_r <= pinSync_r[2];
    end
  end

  assign presetAct = !oeMode_r && presetLvl_r;
  assign outOff = oeMode_r && presetLvl_r;

  // after preset drops, hold off clocking for three more clock edges
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      presetSeq_r <= 3'h0;
    end
    else if (presetAct)
    begin
      presetSeq_r <= 3'h3;
    end
    else if (presetSeq_r != 3'h0)
    begin
      presetSeq_r <= presetSeq_r - 3'h1;
    end
  end

  assign clkRun = !presetAct && (presetSeq_r == 3'h0);

  // ----------------------------------------
  // state and output flip-flops
  // ----------------------------------------
  assign ffNow = {outReg_r, state_r};
  // both set and reset is illegal; kept as hold so nothing random escapes
  assign illegalSr = |(setCmd & rstCmd);
  assign ffNxt = (ffNow | (setCmd & ~rstCmd)) & ~(rstCmd & ~setCmd);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= MLS_FF_RST[MLS_NUM_ST-1:0];
      outReg_r <= MLS_FF_RST[13:MLS_NUM_ST];
    end
    else if (presetAct)
    begin
      state_r <= MLS_FF_RST[MLS_NUM_ST-1:0];
      outReg_r <= MLS_FF_RST[13:MLS_NUM_ST];
    end
    else if (clkRun)
    begin
      state_r <= ffNxt[MLS_NUM_ST-1:0];
      outReg_r <= ffNxt[13:MLS_NUM_ST];
    end
  end

  // ----------------------------------------
  // output buffers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pinOut_r <= 8'hff;
      pinOe_n_r <= 8'h00;
    end
    else
    begin
      pinOut_r <= {state_r[MLS_NUM_SHARED-1:0], outReg_r};
      pinOe_n_r <= {MLS_NUM_PIN{outOff}};
    end
  end

  assign pinOut = pinOut_r;
  assign pinOe_n = pinOe_n_r;
  assign stateBits = state_r;

  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  assign addrTake = hsel && hready && (htrans == MLS_HTRANS_NONSEQ || htrans == MLS_HTRANS_SEQ);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign rdSel = termSel_r;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 12'h000;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wrPend_r <= addrTake && hwrite;
      wrAddr_r <= haddr[11:0];
      if (addrTake && !hwrite)
      begin
        unique case (haddr[11:0])
          MLS_OFF_CTRL: hrdata <= {30'h0, lock_r, oeMode_r};
          MLS_OFF_STATUS: hrdata <= {15'h0, illegalSr, clkRun, presetAct, outReg_r, state_r};
          MLS_OFF_TSEL: hrdata <= {26'h0, termSel_r};
          MLS_OFF_TTRUE: hrdata <= {10'h0, useTrue_r[rdSel]};
          MLS_OFF_TCOMP: hrdata <= {10'h0, useComp_r[rdSel]};
          MLS_OFF_TSET: hrdata <= {18'h0, connSet_r[rdSel]};
          MLS_OFF_TRST: hrdata <= {18'h0, connRst_r[rdSel]};
          MLS_OFF_TCTL: hrdata <= {30'h0, cplDrv_r[rdSel], cplIn_r[rdSel]};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // option is one-time: the lock bit freezes it until reset
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      oeMode_r <= MLS_CTRL_RST[MLS_CTRL_OEMODE];
      lock_r <= MLS_CTRL_RST[MLS_CTRL_LOCK];
    end
    else if (wrPend_r && wrAddr_r == MLS_OFF_CTRL && !lock_r)
    begin
      oeMode_r <= hwdata[MLS_CTRL_OEMODE];
      lock_r <= hwdata[MLS_CTRL_LOCK];
    end
  end

  // virgin array: all AND links intact and no OR links, so every term is dead
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      termSel_r <= 6'h00;
      useTrue_r <= '1;
      useComp_r <= '1;
      connSet_r <= '0;
      connRst_r <= '0;
      cplIn_r <= '0;
      cplDrv_r <= '0;
    end
    else if (wrPend_r)
    begin
      unique case (wrAddr_r)
        MLS_OFF_TSEL: termSel_r <= (hwdata < 32'(MLS_NUM_TERM)) ? hwdata[5:0] : termSel_r;
        MLS_OFF_TTRUE: useTrue_r[termSel_r] <= hwdata[MLS_NUM_VAR-1:0];
        MLS_OFF_TCOMP: useComp_r[termSel_r] <= hwdata[MLS_NUM_VAR-1:0];
        MLS_OFF_TSET: connSet_r[termSel_r] <= hwdata[13:0];
        MLS_OFF_TRST: connRst_r[termSel_r] <= hwdata[13:0];
        MLS_OFF_TCTL:
        begin
          cplIn_r[termSel_r] <= hwdata[MLS_TCTL_CIN];
          cplDrv_r[termSel_r] <= hwdata[MLS_TCTL_CDRV];
        end
        default:
        begin
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== test/mls_ctrl_logic.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// far side: control logic at the pins
// ----------------------------------------
module mls_ctrl_logic
  import mls_pkg::*;
(
  // clock
  input wire logic sys_clk,
  // bench requests
  input wire logic [MLS_NUM_IN-1:0] drvIn,
  input wire logic drvPr,
  // device pins
  input wire logic [MLS_NUM_PIN-1:0] pinOut,
  input wire logic [MLS_NUM_PIN-1:0] pinOe_n,
  output logic [MLS_NUM_IN-1:0] logicInputs,
  output logic presetOrOutputEnable,
  output logic [MLS_NUM_PIN-1:0] pinSeen
);
  import mls_pkg::*;

  logic [MLS_NUM_PIN-1:0] last_r;
  initial
  begin
    logicInputs = '0;
    presetOrOutputEnable = 1'b0;
    last_r = '0;
  end
  // floating pin shows inverse of last level, so a stale value never passes
  assign pinSeen = (pinOut & ~pinOe_n) | (~last_r & pinOe_n);
  always @(posedge sys_clk)
  begin
    logicInputs <= drvIn;
    presetOrOutputEnable <= drvPr;
    // remember only driven levels, so a floating pin stays put
    last_r <= (pinOut & ~pinOe_n) | (last_r & pinOe_n);
  end
endmodule
`default_nettype wire

// ===== test/mls_sequencer_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// port checker
// ----------------------------------------
module mls_sequencer_checker
  import mls_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins
  input wire logic presetOrOutputEnable,
  input wire logic [MLS_NUM_PIN-1:0] pinOut,
  input wire logic [MLS_NUM_PIN-1:0] pinOe_n,
  input wire logic [MLS_NUM_ST-1:0] stateBits
);
  import mls_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic rdReq;
  assign rdReq = hsel && htrans[1] && !hwrite && hreadyout;

  chk_reset_ones: assert property (disable iff (1'b0) !resetn |-> stateBits == 10'h3ff)
    else $error("state not all ones in reset");
  chk_oe_group: assert property (pinOe_n == 8'h00 || pinOe_n == 8'hff)
    else $error("output enables split");
  chk_pin_shared: assert property (pinOut[7:4] == $past(stateBits[3:0]))
    else $error("shared pins differ from low state bits");
  chk_preset_force: assert property (presetOrOutputEnable [*7] ##0 pinOe_n == 8'h00
    |-> stateBits == 10'h3ff && pinOut[3:0] == 4'hf) else $error("preset did not force ones");
  chk_oe_follow: assert property (pinOe_n == 8'hff |-> $past(presetOrOutputEnable, 4)
    || $past(presetOrOutputEnable, 5))
    else $error("pins floated without enable high");
  chk_status_state: assert property (rdReq && haddr == 32'h4 |=>
    hrdata[13:0] == {pinOut[3:0], $past(stateBits)}) else $error("status mismatch");
  chk_rd_unmapped: assert property (rdReq && haddr[11:0] > 12'h01c |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");

  cover property (stateBits == 10'h3fe);
  cover property (pinOe_n == 8'hff);
  cover property (rdReq && haddr == 32'h4);
endmodule
bind mls_sequencer mls_sequencer_checker chk (.sys_clk, .resetn, .hsel, .haddr, .htrans,
  .hwrite, .hrdata, .hreadyout, .hresp, .presetOrOutputEnable, .pinOut, .pinOe_n, .stateBits);
`default_nettype wire

// ===== test/mls_sequencer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module mls_sequencer_tb;
  import mls_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [MLS_NUM_IN-1:0] drvIn = 12'h000;
  logic drvPr = 1'b0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, presetOrOutputEnable;
  logic [MLS_NUM_IN-1:0] logicInputs;
  logic [MLS_NUM_PIN-1:0] pinOut, pinOe_n, pinSeen;
  logic [MLS_NUM_ST-1:0] stateBits;
  int err_total = 0;
  int checked = 0;

  always #25 sys_clk = ~sys_clk;

  mls_sequencer dut (.sys_clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .logicInputs, .presetOrOutputEnable,
    .pinOut, .pinOe_n, .stateBits);
  mls_ctrl_logic far (.sys_clk, .drvIn, .drvPr, .pinOut, .pinOe_n, .logicInputs,
    .presetOrOutputEnable, .pinSeen);

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= w;
    htrans <= MLS_HTRANS_NONSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic prog(input logic [31:0] idx, t, c, s, r, k);
    xfer(1'b1, MLS_OFF_TSEL, idx);
    xfer(1'b1, MLS_OFF_TTRUE, t);
    xfer(1'b1, MLS_OFF_TCOMP, c);
    xfer(1'b1, MLS_OFF_TSET, s);
    xfer(1'b1, MLS_OFF_TRST, r);
    xfer(1'b1, MLS_OFF_TCTL, k);
  endtask
  // sync and input flops take several edges, so wait well past them
  task automatic step(input logic [11:0] in, input logic [9:0] st, input logic [7:0] po);
    drvIn <= in;
    tick(12);
    `CHK("state", st, stateBits)
    `CHK("pins", po, pinSeen)
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    // falling edge at time zero, after the initial high, so the asynchronous reset really fires
    resetn <= 1'b0;
    tick(20);
    `CHK("reset state", 10'h3ff, stateBits)
    `CHK("reset pins", 8'hff, pinSeen)
    resetn <= 1'b1;
    tick(1);
    xfer(1'b0, MLS_OFF_STATUS, 32'h0);
    `CHK("status", 14'h3fff, rd[13:0])
    xfer(1'b0, 12'h040, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
    prog(0, 32'h3, 32'h0, 32'h0, 32'h3c01, 32'h0);
    prog(1, 32'h0, 32'h2, 32'h3fff, 32'h0, 32'h0);
    step(12'h001, 10'h3ff, 8'hff);
    step(12'h003, 10'h3fe, 8'he0);
    xfer(1'b0, MLS_OFF_STATUS, 32'h0);
    `CHK("status run", 14'h03fe, rd[13:0])
    step(12'h002, 10'h3fe, 8'he0);
    step(12'h000, 10'h3ff, 8'hff);
    $display("test terms done");
    drvPr <= 1'b1;
    step(12'h003, 10'h3ff, 8'hff);
    drvPr <= 1'b0;
    step(12'h003, 10'h3fe, 8'he0);
    $display("test preset done");
    step(12'h000, 10'h3ff, 8'hff);
    xfer(1'b1, MLS_OFF_CTRL, 32'h1);
    drvPr <= 1'b1;
    drvIn <= 12'h003;
    tick(10);
    `CHK("state floating", 10'h3fe, stateBits)
    `CHK("enables off", 8'hff, pinOe_n)
    drvPr <= 1'b0;
    tick(10);
    `CHK("enables on", 8'h00, pinOe_n)
    `CHK("pins back", 8'he0, pinSeen)
    $display("test output enable done");
    xfer(1'b1, MLS_OFF_CTRL, 32'h3);
    xfer(1'b1, MLS_OFF_CTRL, 32'h0);
    xfer(1'b0, MLS_OFF_CTRL, 32'h0);
    `CHK("locked option", 32'h3, rd)
    prog(2, 32'h4, 32'h0, 32'h0, 32'h0, 32'h2);
    prog(3, 32'h8, 32'h0, 32'h0, 32'h2, 32'h1);
    xfer(1'b1, MLS_OFF_TSEL, 32'h30);
    xfer(1'b1, MLS_OFF_TSEL, 32'h40);
    xfer(1'b0, MLS_OFF_TSEL, 32'h0);
    `CHK("term index", 32'h3, rd)
    step(12'h00e, 10'h3fe, 8'he0);
    step(12'h00a, 10'h3fc, 8'hc0);
    $display("test complement done");
    end_of_test();
  end

  initial
  begin
    repeat (2000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
